// ==== design/dhr_pkg.sv ====
// Purpose: shared constants and types for the d-channel hdlc receiver
// Assumes: one 25 MHz clock, serial bits qualified by a strobe
// Notes: bit positions index 8-bit ports
package dhr_pkg;

  localparam logic [7:0] FLAG_PAT = 8'h7e;       // 01111110
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_GOOD = 16'h1d0f;   // residue, msb first
  localparam logic [4:0] STUFF_ONES = 5'h05;
  localparam logic [4:0] ABORT_ONES = 5'h06;     // seventh one ends frame
  localparam logic [4:0] MARK_IDLE_ONES = 5'h0f;
  localparam logic [3:0] FLAG_GAP_BITS = 4'h7;
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0005;

  // fifo width in bits, depths in entries
  localparam int unsigned FIFO_WIDTH = 9;        // data plus last marker
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [5:0] DEPTH_NORMAL = 6'h08;
  localparam logic [5:0] DEPTH_EXTENDED = 6'h20;

  // control bit positions
  localparam int unsigned M1_THR_IRQ = 1;        // dlink_mode_one
  localparam int unsigned M1_EOF_IRQ = 3;
  localparam int unsigned M1_PAIR_EN_LO = 4;     // bits 4..7
  localparam int unsigned M3_ADDR_IRQ = 0;       // rx_irq_mode
  localparam int unsigned M3_LAST_IRQ = 2;
  localparam int unsigned M3_AVAIL_IRQ = 3;
  localparam int unsigned M3_CRC_STORE = 7;
  localparam int unsigned M4_THR_LO = 2;         // fifo_addr_mode
  localparam int unsigned M4_BYTE_ONLY = 5;
  localparam int unsigned M4_CR_CMP = 6;
  localparam int unsigned M4_SECOND_ONLY = 7;
  localparam int unsigned EFC_EXTEND = 0;

  // error byte positions
  localparam int unsigned ERR_ABORT = 0;
  localparam int unsigned ERR_NONINT = 1;
  localparam int unsigned ERR_CRC = 3;
  localparam int unsigned ERR_OVERFLOW = 4;
  localparam int unsigned ERR_UNDERFLOW = 5;
  localparam int unsigned ERR_OVERRUN = 6;

  // status positions
  localparam int unsigned S1_ADDR = 0;
  localparam int unsigned S1_EOF = 1;
  localparam int unsigned S1_BUSY = 2;
  localparam int unsigned S2_LOST = 2;
  localparam int unsigned S2_MARK_IDLE = 5;
  localparam int unsigned S2_FLAG_IDLE = 6;

  // receive threshold choices, indexed by the two threshold bits
  localparam logic [23:0] THR_NORMAL = {6'h08, 6'h04, 6'h02, 6'h01};
  localparam logic [23:0] THR_EXTENDED = {6'h20, 6'h10, 6'h08, 6'h04};

  typedef enum logic [2:0] {
    ST_HUNT = 3'b000,
    ST_OPEN = 3'b001,
    ST_RECV = 3'b010,
    ST_DROP = 3'b011,
    ST_END = 3'b100
  } dhr_state_e;

endpackage

// ==== design/dhr_receiver.sv ====
// Purpose: receive side of a d-channel hdlc link controller with fifo
// Assumes: rx_bit_valid_i pulses no more often than once every 4 clocks
// Notes: software side is plain strobes; outputs come from flops, except the two idle bits of link_status_two_o, decoded from registered counters
//
// Overview of operation
// R1 - two-byte mode: both bytes must match one enabled pair
// R2 - no pair enabled: accept all, end-of-address after byte two
// R3 - extension clear or reset: 8-byte fifos
// R4 - extension set: 32-byte fifo, alternate thresholds
// R5 - opening flag plus one non-flag byte sets busy, unless two frames are outstanding
// R6 - recognition on: unmatched dropped, matched received
// R7 - address events set irq bit 2 and status-one bit 0, maskable
// R8 - three-byte hold so address precedes readable data
// R9 - data-available and threshold irqs, separately masked
// R10 - crc bytes stored only when store bit set
// R11 - maskable irq on read of a frame's final byte
// R12 - closing flag, abort, overflow or overrun ends frame
// R13 - two-deep 16-bit count fifo, written with last byte
// R14 - last read pops errors; count read pops count and address status
// R15 - count above limit ends frame, error bit 4
// R16 - two-byte-address frame under 5 bytes: error bit 5
// R17 - byte into full fifo ends frame, error bit 6
// R18 - third frame with two outstanding refused, status-two bit 2
// R19 - seven-ones abort in error bit 0
// R20 - bit count not multiple of eight: error bit 1
// R21 - bad crc residue at closing flag: error bit 3
// R22 - unaligned frames, shared flags, mark-idle and flag-idle status
// R23 - software abort ends frame in progress
// R24 - c/r bit of first-byte match ignored unless compare bit set
// R25 - zero after five ones deleted inside frame
// R26 - seven ones inside a frame abort it
`timescale 1ns/1ns

module dhr_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] limit_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [5:0] level_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [5:0] level_r;
  logic do_wr;
  logic do_rd;

  // ready honours the active depth
  assign in_ready_o = (level_r < limit_i);
  assign out_valid_o = (level_r != 6'h00);
  assign out_data_o = mem[rptr_r];
  assign level_o = level_r;
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      level_r <= 6'h00;
    end else begin
      if (do_wr) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (do_rd) begin
        rptr_r <= rptr_r + 1'b1;
      end
      level_r <= level_r + {5'h00, do_wr} - {5'h00, do_rd};
    end
  end

  // storage has no reset, only the pointers matter
  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem[wptr_r] <= in_data_i;
    end
  end
endmodule // dhr_fifo

module dhr_receiver
  import dhr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic [7:0] dlink_mode_one_i,
  input wire logic [7:0] error_mask_mode_i,
  input wire logic [7:0] rx_irq_mode_i,
  input wire logic [7:0] fifo_addr_mode_i,
  input wire logic fifo_extension_ctrl_i,
  input wire logic [31:0] first_byte_match_i,
  input wire logic [31:0] second_byte_match_i,
  input wire logic [15:0] rx_byte_limit_i,
  input wire logic rx_abort_i,
  input wire logic rx_data_rd_i,
  input wire logic rx_count_rd_i,
  input wire logic status_one_rd_i,
  input wire logic status_two_rd_i,
  output logic [7:0] rx_data_port_o,
  output logic rx_data_last_o,
  output logic rx_data_valid_o,
  output logic [15:0] rx_count_fifo_o,
  output logic [7:0] addr_status_fifo_o,
  output logic [7:0] rx_error_fifo_o,
  output logic [7:0] link_status_one_o,
  output logic [7:0] link_status_two_o,
  output logic [7:0] irq_register_o,
  output logic rx_avail_irq_o,
  output logic rx_thresh_irq_o,
  output logic rx_last_irq_o,
  output logic rx_eof_irq_o,
  output logic rx_err_irq_o
);

  typedef struct packed {
    dhr_state_e st;
    logic [4:0] ones;
    logic [7:0] win;
    logic [6:0] dly;
    logic [2:0] dn;
    logic [7:0] asm_b;
    logic [2:0] an;
    logic [15:0] crc;
    logic [23:0] hold;        // three held bytes, oldest in low byte
    logic [1:0] hn;
    logic [1:0] pn;
    logic reopen;
    logic [15:0] fcnt;
    logic [15:0] pcnt;
    logic [7:0] ferr;
    logic [7:0] fas;
    logic [7:0] addr0;
    logic [3:0] fsince;
    logic [1:0] frun;
    logic [31:0] cq;
    logic [15:0] aq;
    logic [1:0] cn;
    logic [15:0] eq;
    logic [1:0] en;
    logic [7:0] s1;
    logic lost;
    logic [7:0] rdat;
    logic rlast;
    logic rval;
    logic [15:0] cnt_o;
    logic [7:0] as_o;
    logic [7:0] err_o;
    logic irq2;
    logic avail;
    logic thr;
    logic lirq;
    logic eirq;
    logic errirq;
  } dhr_state_s;

  dhr_state_s r;
  dhr_state_s n;

  logic push;
  logic [8:0] push_d;
  logic f_ready;
  logic f_valid;
  logic [8:0] f_data;
  logic [5:0] f_level;
  logic [5:0] f_limit;
  logic [23:0] thr_tab;
  logic [5:0] thr_lvl;

  // one lsb-first crc step, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15-i];
    end
  endfunction

  // per-pair match vector
  function automatic logic [3:0] addr_hits(input logic [7:0] b0, input logic [7:0] b1,
                                           input logic [7:0] m4, input logic [31:0] fm,
                                           input logic [31:0] sm);
    logic [7:0] care;
    logic f;
    logic s;
    care = m4[M4_CR_CMP] ? 8'hff : 8'hfd;   // [R24]
    for (int i = 0; i < 4; i++) begin
      f = ((b0 ^ fm[i*8 +: 8]) & care) == 8'h00;
      s = (b1 == sm[i*8 +: 8]);
      if (!m4[M4_BYTE_ONLY]) begin
        addr_hits[i] = f && s;           // [R1]
      end else if (m4[M4_SECOND_ONLY]) begin
        addr_hits[i] = s;
      end else begin
        addr_hits[i] = f;
      end
    end
  endfunction

  // active depth and threshold follow the extension bit
  assign f_limit = fifo_extension_ctrl_i ? DEPTH_EXTENDED : DEPTH_NORMAL;  // [R3] [R4]
  assign thr_tab = fifo_extension_ctrl_i ? THR_EXTENDED : THR_NORMAL;      // [R4]
  assign thr_lvl = thr_tab[fifo_addr_mode_i[M4_THR_LO +: 2]*6 +: 6];

  dhr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .limit_i(f_limit),
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i(push_d),
    .out_valid_o(f_valid),
    .out_ready_i(rx_data_rd_i),
    .out_data_o(f_data),
    .level_o(f_level)
  );

  // receiver next state
  always_comb begin
    logic raw;
    logic ob;
    logic flag;
    logic abort7;
    logic byte_ev;
    logic [7:0] nb;
    logic term;
    logic closing;
    logic [7:0] terr;
    logic [3:0] hits;
    logic rd_last;
    raw = rx_bit_i;
    ob = 1'b0;
    flag = 1'b0;
    abort7 = 1'b0;
    byte_ev = 1'b0;
    nb = 8'h00;
    term = 1'b0;
    closing = 1'b0;
    terr = 8'h00;
    hits = 4'h0;
    rd_last = 1'b0;
    push = 1'b0;
    push_d = 9'h000;
    n = r;
    n.rval = 1'b0;
    n.irq2 = 1'b0;
    n.lirq = 1'b0;
    n.errirq = 1'b0;
    // clears first so a same-cycle event still sets its bit
    if (status_one_rd_i) begin
      n.s1[S1_ADDR] = 1'b0;
      n.s1[S1_EOF] = 1'b0;
    end
    if (status_two_rd_i) begin
      n.lost = 1'b0;
    end

    if (rx_bit_valid_i && r.st != ST_END) begin
      n.win = {raw, r.win[7:1]};
      n.ones = raw ? ((r.ones == 5'h1f) ? r.ones : r.ones + 5'h01) : 5'h00;
      flag = (n.win == FLAG_PAT);
      abort7 = raw && (r.ones == ABORT_ONES);
      n.fsince = (r.fsince == 4'hf) ? r.fsince : r.fsince + 4'h1;
      if (flag) begin
        // back-to-back flags build the flag-idle run
        n.frun = (r.fsince == FLAG_GAP_BITS && r.frun != 2'h3) ? r.frun + 2'h1 : 2'h0;  // [R22]
        n.fsince = 4'h0;
      end else if (r.fsince > FLAG_GAP_BITS) begin
        n.frun = 2'h0;
      end
      case (r.st)
        ST_HUNT, ST_DROP: begin
          if (flag) begin
            n.st = ST_OPEN;
          end else if (abort7) begin
            n.st = ST_HUNT;
          end
        end
        ST_OPEN, ST_RECV: begin
          if (abort7) begin
            if (r.st == ST_RECV) begin
              term = 1'b1;                 // [R26]
              terr[ERR_ABORT] = 1'b1;      // [R19]
            end else begin
              n.st = ST_HUNT;
            end
          end else if (flag) begin
            if (r.st == ST_RECV) begin
              term = 1'b1;
              closing = 1'b1;
              terr[ERR_NONINT] = (r.an != 3'h0);                   // [R20]
              terr[ERR_CRC] = (rev16(r.crc) != CRC_GOOD);          // [R21]
            end
          end else if (!(raw == 1'b0 && r.ones == STUFF_ONES)) begin  // [R25]
            // seven-bit lag keeps flag bits out of the data
            n.dly = {raw, r.dly[6:1]};
            if (r.dn == 3'h7) begin
              ob = r.dly[0];
              n.crc = crc_step(r.crc, ob);
              n.asm_b = {ob, r.asm_b[7:1]};
              n.an = r.an + 3'h1;
              byte_ev = (r.an == 3'h7);
              nb = n.asm_b;
            end else begin
              n.dn = r.dn + 3'h1;
            end
          end
        end
        default: begin
          n.st = r.st;
        end
      endcase
    end

    // a new opening flag restarts the per-frame state
    if (flag && (r.st != ST_RECV) && (r.st != ST_END)) begin
      n.dn = 3'h0;
      n.an = 3'h0;
      n.crc = CRC_INIT;
      n.fcnt = 16'h0000;
      n.hn = 2'h0;
      n.ferr = 8'h00;
      n.fas = 8'h00;
    end

    // completed byte handling
    if (byte_ev) begin
      n.fcnt = r.fcnt + 16'h0001;
      if (r.st == ST_OPEN) begin
        if (r.cn == 2'h2) begin
          n.lost = 1'b1;                 // [R18]
          n.st = ST_DROP;
        end else begin
          n.st = ST_RECV;
          n.s1[S1_BUSY] = 1'b1;          // [R5]
        end
      end
      if (n.st == ST_RECV) begin
        if (r.hn == 2'h3) begin
          // oldest held byte leaves; full fifo means overrun
          push = 1'b1;                   // [R8]
          push_d = {1'b0, r.hold[7:0]};
          n.hold = {nb, r.hold[23:8]};
          if (!f_ready) begin
            term = 1'b1;                 // [R17]
            terr[ERR_OVERRUN] = 1'b1;
          end
        end else begin
          n.hold[r.hn*8 +: 8] = nb;
          n.hn = r.hn + 2'h1;
        end
        if (r.fcnt == 16'h0000) begin
          n.addr0 = nb;
        end
        if (r.fcnt == 16'h0001) begin
          hits = addr_hits(r.addr0, nb, fifo_addr_mode_i, first_byte_match_i,
                           second_byte_match_i) & dlink_mode_one_i[M1_PAIR_EN_LO +: 4];
          n.fas = {4'h0, hits};
          if (dlink_mode_one_i[M1_PAIR_EN_LO +: 4] == 4'h0 || hits != 4'h0) begin  // [R2] [R6]
            if (rx_irq_mode_i[M3_ADDR_IRQ]) begin
              n.irq2 = 1'b1;             // [R7]
              n.s1[S1_ADDR] = 1'b1;
            end
          end else begin
            n.st = ST_DROP;              // [R6]
            n.s1[S1_BUSY] = 1'b0;
          end
        end
        if (n.fcnt > rx_byte_limit_i) begin
          term = 1'b1;                   // [R15]
          terr[ERR_OVERFLOW] = 1'b1;
        end
      end
    end
    if (push && f_ready) begin
      n.pcnt = r.pcnt + 16'h0001;
    end

    // software abort of the frame in progress
    if (rx_abort_i && !term) begin
      if (r.st == ST_RECV) begin
        term = 1'b1;                     // [R23]
        terr[ERR_ABORT] = 1'b1;
      end else if (r.st == ST_OPEN) begin
        n.st = ST_HUNT;
      end
    end

    // frame end; held bytes drain in end state
    if (term) begin
      n.st = ST_END;                     // [R12]
      n.reopen = closing;
      n.ferr = r.ferr | terr;
      // an aborted frame reports only its abort, not its length
      n.ferr[ERR_UNDERFLOW] = closing && !r.addr0[0] && (n.fcnt < MIN_FRAME_LEN);  // [R16]
      n.pn = (closing && !rx_irq_mode_i[M3_CRC_STORE] && n.hn == 2'h3) ? 2'h1 : n.hn;  // [R10]
      n.s1[S1_EOF] = 1'b1;
      n.s1[S1_BUSY] = 1'b0;
    end

    if (r.st == ST_END) begin
      if (r.pn != 2'h0) begin
        push = 1'b1;
        push_d = {(r.pn == 2'h1), r.hold[7:0]};
        n.hold = {8'h00, r.hold[23:8]};
        n.pn = r.pn - 2'h1;
        if (f_ready) begin
          n.pcnt = r.pcnt + 16'h0001;
        end else begin
          n.ferr[ERR_OVERRUN] = 1'b1;    // [R17]
        end
      end
      if (r.pn <= 2'h1) begin
        // record the finished frame
        n.cq[r.cn[0]*16 +: 16] = n.pcnt;   // [R13]
        n.aq[r.cn[0]*8 +: 8] = r.fas;
        n.eq[r.en[0]*8 +: 8] = n.ferr;
        n.cn = r.cn + 2'h1;
        n.en = r.en + 2'h1;
        n.pcnt = 16'h0000;
        n.hn = 2'h0;
        n.st = r.reopen ? ST_OPEN : ST_HUNT;
        n.dn = 3'h0;
        n.an = 3'h0;
        n.crc = CRC_INIT;
        n.fcnt = 16'h0000;
        n.ferr = 8'h00;
      end
    end

    // software reads of the data port and the queues
    if (rx_data_rd_i && f_valid) begin
      n.rdat = f_data[7:0];
      n.rlast = f_data[8];
      n.rval = 1'b1;
      rd_last = f_data[8];
    end
    if (rd_last) begin
      n.lirq = rx_irq_mode_i[M3_LAST_IRQ];                    // [R11]
      n.err_o = r.eq[7:0];                                    // [R14]
      n.errirq = |(r.eq[7:0] & error_mask_mode_i);
      n.eq = {8'h00, n.eq[15:8]};
      n.en = n.en - 2'h1;
    end
    if (rx_count_rd_i && r.cn != 2'h0) begin
      n.cq = {16'h0000, n.cq[31:16]};                        // [R14]
      n.aq = {8'h00, n.aq[15:8]};
      n.cn = n.cn - 2'h1;
    end
    n.cnt_o = n.cq[15:0];
    n.as_o = n.aq[7:0];
    n.avail = f_valid && rx_irq_mode_i[M3_AVAIL_IRQ];               // [R9]
    n.thr = (f_level >= thr_lvl) && dlink_mode_one_i[M1_THR_IRQ];  // [R9]
    n.eirq = n.s1[S1_EOF] && dlink_mode_one_i[M1_EOF_IRQ];         // [R12]
  end

  // single state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.crc <= CRC_INIT;
    end else begin
      r <= n;
    end
  end

  assign rx_data_port_o = r.rdat;
  assign rx_data_last_o = r.rlast;
  assign rx_data_valid_o = r.rval;
  assign rx_count_fifo_o = r.cnt_o;
  assign addr_status_fifo_o = r.as_o;
  assign rx_error_fifo_o = r.err_o;
  assign link_status_one_o = r.s1;
  // idle levels from registered counters
  assign link_status_two_o = {1'b0, (r.frun > 2'h2), (r.ones >= MARK_IDLE_ONES), 2'b00,
                              r.lost, 2'b00};  // [R22]
  assign irq_register_o = {5'h00, r.irq2, 2'b00};
  assign rx_avail_irq_o = r.avail;
  assign rx_thresh_irq_o = r.thr;
  assign rx_last_irq_o = r.lirq;
  assign rx_eof_irq_o = r.eirq;
  assign rx_err_irq_o = r.errirq;

endmodule // dhr_receiver

// ==== test/dhr_receiver_assertions.sv ====
// Purpose: concurrent checks on the receiver's software-side outputs
// Assumes: control inputs change only between frames, fifo drained
// Notes: bound onto every dhr_receiver instance
`timescale 1ns/1ns
module dhr_receiver_assertions
  import dhr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] dlink_mode_one_i,
  input wire logic [7:0] error_mask_mode_i,
  input wire logic [7:0] rx_irq_mode_i,
  input wire logic rx_data_rd_i,
  input wire logic rx_data_valid_o,
  input wire logic rx_data_last_o,
  input wire logic [7:0] rx_error_fifo_o,
  input wire logic [7:0] link_status_one_o,
  input wire logic [7:0] irq_register_o,
  input wire logic rx_thresh_irq_o,
  input wire logic rx_last_irq_o,
  input wire logic rx_eof_irq_o,
  input wire logic rx_err_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // read answers follow a strobe
  chk_read_answer: assert property (rx_data_valid_o |-> $past(rx_data_rd_i))
    else $error("valid without read");
  chk_last_cause: assert property (rx_last_irq_o |-> rx_data_valid_o && rx_data_last_o)
    else $error("last irq without last");
  chk_last_fire: assert property (rx_data_valid_o && rx_data_last_o
    && rx_irq_mode_i[M3_LAST_IRQ] |-> rx_last_irq_o ##1 !rx_last_irq_o)
    else $error("last irq bad");
  // error irq follows masked error byte
  chk_err_cause: assert property (rx_err_irq_o |-> rx_data_last_o
    && (rx_error_fifo_o & error_mask_mode_i) != 8'h00)
    else $error("err irq unexpected");
  chk_err_fire: assert property (rx_data_valid_o && rx_data_last_o
    && (rx_error_fifo_o & error_mask_mode_i) != 8'h00 |-> rx_err_irq_o)
    else $error("err irq missing");
  // address event in both places, only when enabled
  chk_addr_event: assert property (irq_register_o[2] |-> ##[0:1] link_status_one_o[S1_ADDR])
    else $error("addr irq no status");
  chk_addr_mask: assert property (irq_register_o[2] |-> $past(rx_irq_mode_i[M3_ADDR_IRQ]))
    else $error("addr irq masked");
  chk_eof_mask: assert property (rx_eof_irq_o |-> dlink_mode_one_i[M1_EOF_IRQ])
    else $error("eof irq masked");
  chk_thr_mask: assert property (rx_thresh_irq_o |-> dlink_mode_one_i[M1_THR_IRQ])
    else $error("thr irq masked");
  cover property (rx_last_irq_o);
  cover property (rx_err_irq_o);
  cover property (irq_register_o[2]);
endmodule // dhr_receiver_assertions

bind dhr_receiver dhr_receiver_assertions u_chk (.*);

// ==== test/dhr_line_model.sv ====
// Purpose: line-side model sending serial d-channel bits
// Assumes: strobes 5 clocks apart
// Notes: zero stuffing done here
`timescale 1ns/1ns
module dhr_line_model (
  input wire logic mclk_i,
  output logic bit_o,
  output logic valid_o
);
  int ones;
  initial begin
    bit_o = 1'b1;
    valid_o = 1'b0;
    ones = 0;
  end
  // data flips after the strobe
  task automatic put(input logic b);
    repeat (4) @(posedge mclk_i);
    bit_o <= b;
    valid_o <= 1'b1;
    @(posedge mclk_i);
    bit_o <= ~b;
    valid_o <= 1'b0;
  endtask
  // frame byte lsb first, zero inserted after five ones
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask
  // flags and aborts bypass stuffing
  task automatic send_raw(input logic [7:0] v);
    for (int i = 0; i < 8; i++) put(v[i]);
    ones = 0;
  endtask
endmodule // dhr_line_model

// ==== test/test_dchannel_hdlc_receiver.sv ====
// Purpose: self-checking bench for the d-channel receiver
// Assumes: line model drives serial bits, bench acts as software
// Notes: abort frames check only the error byte, data is don't-care
`timescale 1ns/1ns
module test_dchannel_hdlc_receiver;
  import dhr_pkg::*;
  typedef struct {logic [7:0] d; logic last; logic [7:0] err; bit any;} dhr_note_s;
  logic mclk_i, rst_n_i, rx_bit_i, rx_bit_valid_i, fifo_extension_ctrl_i, rx_abort_i;
  logic rx_data_rd_i, rx_count_rd_i, status_one_rd_i, status_two_rd_i;
  logic [7:0] dlink_mode_one_i, error_mask_mode_i, rx_irq_mode_i, fifo_addr_mode_i;
  logic [31:0] first_byte_match_i, second_byte_match_i, lfsr;
  logic [15:0] rx_byte_limit_i, rx_count_fifo_o;
  logic [7:0] rx_data_port_o, addr_status_fifo_o, rx_error_fifo_o;
  logic [7:0] link_status_one_o, link_status_two_o, irq_register_o;
  logic rx_data_last_o, rx_data_valid_o, rx_avail_irq_o, rx_thresh_irq_o;
  logic rx_last_irq_o, rx_eof_irq_o, rx_err_irq_o;
  int errors, checks_done, cycles;
  dhr_note_s q[$];
  dhr_note_s n;
  logic [15:0] counts[$];

  dhr_receiver DUT (.*);
  dhr_line_model line (.mclk_i(mclk_i), .bit_o(rx_bit_i), .valid_o(rx_bit_valid_i));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reflected crc, one byte lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    return c;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic set_mode(input logic [7:0] m1, m3, m4, input logic ext);
    @(posedge mclk_i);
    dlink_mode_one_i <= m1;
    rx_irq_mode_i <= m3;
    fifo_addr_mode_i <= m4;
    fifo_extension_ctrl_i <= ext;
  endtask

  // address, n data bytes (first ff forces stuffing), fcs
  task automatic send_frame(input logic [7:0] a0, a1, input int n, input bit bad, keep, acc,
                            input logic [7:0] err);
    logic [7:0] b[$];
    logic [15:0] c;
    int cnt;
    b = {a0, a1};
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      b.push_back(i == 0 ? 8'hff : lfsr[7:0]);
    end
    c = CRC_INIT;
    foreach (b[i]) c = crc_step(c, b[i]);
    c = ~c ^ {15'h0, bad};
    cnt = keep ? b.size() + 2 : b.size();
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    line.send_raw(FLAG_PAT);
    foreach (b[i]) line.send_byte(b[i]);
    line.send_raw(FLAG_PAT);
    repeat (40) @(posedge mclk_i);
    if (acc) begin
      for (int i = 0; i < cnt; i++) q.push_back('{b[i], i == cnt - 1, err, 1'b0});
      counts.push_back(cnt[15:0]);
    end
  endtask

  // read to the frame's last byte or budget; left = notes of later frames
  task automatic drain(input bit any, input int lim, input int left = 0);
    int k;
    k = 0;
    while (k < lim) begin
      @(posedge mclk_i) rx_data_rd_i <= 1'b1;
      @(posedge mclk_i) rx_data_rd_i <= 1'b0;
      @(negedge mclk_i);
      k = (rx_data_valid_o === 1'b1 && rx_data_last_o === 1'b1) ? lim : k + 1;
    end
    // let the watcher take the last note first
    @(negedge mclk_i);
    if (!any) check("notes left", left[15:0], q.size());
    else q.delete();
  endtask

  // count checked, then popped with status reads
  task automatic pop_count(input bit chk);
    logic [15:0] e;
    e = counts.size() ? counts.pop_front() : 16'h0;
    if (chk) check("rx count", e, rx_count_fifo_o);
    @(posedge mclk_i);
    {rx_count_rd_i, status_one_rd_i, status_two_rd_i} <= 3'h7;
    @(posedge mclk_i);
    {rx_count_rd_i, status_one_rd_i, status_two_rd_i} <= 3'h0;
    @(negedge mclk_i);
  endtask

  // output watcher: each read answer takes the oldest note
  always @(negedge mclk_i) begin
    if (rx_data_valid_o === 1'b1) begin
      if (q.size() == 0) check("unexpected byte", 16'h0, 16'h1);
      else begin
        n = q.pop_front();
        if (!n.any) check("rx byte", {n.last, n.d}, {rx_data_last_o, rx_data_port_o});
        if (rx_data_last_o === 1'b1) check("rx error", n.err, rx_error_fifo_o);
      end
    end
  end

  // hang guard, far above the run's length
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    {rst_n_i, rx_abort_i, rx_data_rd_i, rx_count_rd_i} = 4'h0;
    {status_one_rd_i, status_two_rd_i, fifo_extension_ctrl_i} = 3'h0;
    {dlink_mode_one_i, rx_irq_mode_i, fifo_addr_mode_i} = {8'h0a, 8'h8d, 8'h00};
    {first_byte_match_i, second_byte_match_i} = 64'h0;
    error_mask_mode_i = 8'hff;
    rx_byte_limit_i = 16'h0040;
    lfsr = 32'h922f;
    {errors, checks_done, cycles} = 0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // no recognition; bad crc; short frame
    send_frame(8'h02, 8'h01, 3, 0, 1, 1, 8'h00);
    check("addr event", 16'h1, link_status_one_o[S1_ADDR]);
    check("end of frame", 16'h1, link_status_one_o[S1_EOF]);
    drain(0, 40);
    pop_count(1);
    set_mode(8'h0a, 8'h0d, 8'h00, 0);
    send_frame(8'h02, 8'h01, 2, 1, 0, 1, 8'h08);
    drain(0, 40);
    pop_count(1);
    set_mode(8'h0a, 8'h8d, 8'h00, 0);
    send_frame(8'h02, 8'h01, 0, 0, 1, 1, 8'h20);
    drain(0, 40);
    pop_count(1);
    // pair 0 with c/r ignored, then compared
    set_mode(8'h1a, 8'h8c, 8'h00, 0);
    second_byte_match_i <= 32'h0000_0001;
    send_frame(8'h02, 8'h01, 2, 0, 1, 1, 8'h00);
    check("masked addr event", 16'h0, link_status_one_o[S1_ADDR]);
    set_mode(8'h1a, 8'h8c, 8'h40, 0);
    send_frame(8'h02, 8'h01, 2, 0, 1, 0, 8'h00);
    drain(0, 40);
    check("addr status", 16'h1, addr_status_fifo_o);
    pop_count(1);
    drain(0, 4);
    // extended fifo holds two frames; the third is refused
    set_mode(8'h0a, 8'h8d, 8'h00, 1);
    send_frame(8'h02, 8'h01, 3, 0, 1, 1, 8'h00);
    send_frame(8'h02, 8'h01, 3, 0, 1, 1, 8'h00);
    send_frame(8'h02, 8'h01, 3, 0, 1, 0, 8'h00);
    check("frame lost", 16'h1, link_status_two_o[S2_LOST]);
    drain(0, 40, 7);
    pop_count(1);
    drain(0, 40);
    pop_count(1);
    // seven ones on the line end the frame
    set_mode(8'h0a, 8'h8d, 8'h00, 0);
    line.send_raw(FLAG_PAT);
    for (int i = 0; i < 5; i++) line.send_byte(i == 2 ? 8'hff : 8'h02 >> i);
    line.send_raw(8'hff);
    line.send_raw(FLAG_PAT);
    repeat (40) @(posedge mclk_i);
    repeat (6) q.push_back('{8'h00, 1'b0, 8'h01, 1'b1});
    drain(1, 10);
    pop_count(0);
    // software abort mid-frame, then a reset in mid-run
    line.send_raw(FLAG_PAT);
    line.send_byte(8'h02);
    line.send_byte(8'h01);
    line.send_byte(8'hff);
    @(posedge mclk_i) rx_abort_i <= 1'b1;
    @(posedge mclk_i) rx_abort_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check("abort end", 16'h1, link_status_one_o[S1_EOF]);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    report_and_stop();
  end
endmodule // test_dchannel_hdlc_receiver
